// ===== src/lmp_defines.vh
/*
  Constants for the LED mode and protection controller: register offsets,
  field positions, reset values and timing counts.
  Assumes a 50 MHz clock and a byte-wide register port behind an I2C slave.
*/
`ifndef LMP_DEFINES_VH
`define LMP_DEFINES_VH

// ==========================================================
// Register offsets
`define LMP_ADDR_CFG_A      8'h01
`define LMP_ADDR_CFG_B      8'h02
`define LMP_ADDR_TORCH      8'h05
`define LMP_ADDR_PHREF      8'h06
`define LMP_ADDR_THERM      8'h09
`define LMP_ADDR_STATUS     8'h17

// ==========================================================
// Field positions, config register A
`define LMP_A_LED1          0
`define LMP_A_LED2          1
`define LMP_A_THERM_EN      3
`define LMP_A_PH_BIAS       4
`define LMP_A_PH_SENSE      5
`define LMP_A_PL_FORCE      6
// Field positions, config register B
`define LMP_B_PRECHARGE     1
`define LMP_B_PUMP_EN       2
`define LMP_B_EXT_TRIG      3
`define LMP_B_I2C_TRIG      4
`define LMP_B_FLASH_SEL     5
`define LMP_B_PUMP_FLASH    6
`define LMP_B_IND_EN        7
// Thermistor register: clear bit on top of the threshold field.
`define LMP_T_CLEAR         7

// ==========================================================
// Reset values and thresholds
`define LMP_RST_CFG_A       8'h00
`define LMP_RST_CFG_B       8'h00
`define LMP_RST_TORCH       8'h00
`define LMP_RST_PHREF       8'h00
`define LMP_RST_THERM       8'h00
`define LMP_TORCH_LIMIT     8'h3F

// ==========================================================
// Timing
`define LMP_CLK_HZ          32'h02FA_F080
`define LMP_PL_TIMEOUT_MS   32'h0000_00C8
`define LMP_PL_TIMEOUT_CYC  ((`LMP_CLK_HZ / 32'h0000_03E8) * `LMP_PL_TIMEOUT_MS)

`endif

// ===== src/lmp_sync.v
/*
  Two flip-flop synchroniser for a bus of asynchronous levels.
  Assumes inputs are quasi-static levels from pins or comparators.
*/
`timescale 1ns/1ps
`default_nettype none
module lmp_sync #(
  parameter W = 1
) (
  input  wire         clk,
  input  wire         reset_n,
  input  wire [W-1:0] din,
  output reg  [W-1:0] dout
);
  reg [W-1:0] stage;

  // ==========================================================
  // Synchroniser
  // The first stage feeds only the second, to bound metastability.
  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      stage <= {W{1'b0}};
      dout  <= {W{1'b0}};
    end
    else
    begin
      stage <= din;
      dout  <= stage;
    end
  end
endmodule
`default_nettype wire

// ===== src/lmp_timer.v
/*
  Picture-light time-out counter.
  Assumes run is a level; done rises after LIMIT cycles of run and holds.
*/
`timescale 1ns/1ps
`default_nettype none
module lmp_timer #(
  parameter [31:0] LIMIT = 32'h0098_9680
) (
  input  wire clk,
  input  wire reset_n,
  input  wire run,
  output reg  done
);
  reg [31:0] count;

  // ==========================================================
  // Counter
  always @(posedge clk)
  begin
    if (!reset_n || !run)
    begin
      count <= 32'h0000_0000;
      done  <= 1'b0;
    end
    else if (count >= LIMIT - 32'h0000_0001)
    begin
      done <= 1'b1;
    end
    else
    begin
      count <= count + 32'h0000_0001;
    end
  end
endmodule
`default_nettype wire

// ===== src/lmp_led_mode_ctrl.v
/*
  Mode and protection control for a dual-LED flash driver: torch/video,
  indicator, photo-sense cut-off latch, picture-light time-out and
  thermistor shutdown latch, behind a byte register port.
  Assumes an I2C slave front end drives the register port on clk, and that
  comparator and pin inputs are asynchronous to clk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "lmp_defines.vh"
module lmp_led_mode_ctrl #(
  parameter [31:0] PL_TIMEOUT_CYC = `LMP_PL_TIMEOUT_CYC
) (
  input  wire       clk,
  input  wire       reset_n,
  input  wire [7:0] regAddr,
  input  wire [7:0] regWrData,
  input  wire       regWr,
  input  wire       regRd,
  output reg  [7:0] regRdData,
  input  wire       flashTriggerPin,
  input  wire       lightAboveRef,
  input  wire       thermistorBelowRef,
  input  wire       flashPulseRequest,
  output reg        flashOn,
  output reg        torchOn,
  output reg        pictureLightOn,
  output reg        indicatorFirstOn,
  output reg        indicatorSecondOn,
  output reg        gateDriveFirst,
  output reg        gateDriveSecond,
  output reg        pumpOn,
  output reg        sensorBiasOut,
  output reg        flashTimeoutEnable,
  output reg        pictureTimeoutExpired,
  output reg  [7:0] torchCurrentLevel,
  output reg  [7:0] photoReference,
  output reg  [6:0] thermistorThreshold
);
  // ==========================================================
  // Registers
  reg  [7:0] cfgA;
  reg  [7:0] cfgB;
  reg  [7:0] torchReg;
  reg  [7:0] phRef;
  reg  [7:0] thermReg;
  reg        lightLatch;
  reg        thermFault;
  reg        clearSeen;
  reg        trigPinPrev;
  reg        i2cTrigPrev;
  wire [2:0] syncIn;
  wire [2:0] syncOut;
  wire       trigPin;
  wire       lightHigh;
  wire       thermLow;
  wire       plExpired;
  wire       rearm;
  wire       indicatorEn;
  wire       flashSelect;
  wire       ledAny;
  wire       pumpReq;
  wire       flashActive;
  wire       torchActive;
  wire       plActive;
  wire       plTimerRun;
  reg  [7:0] next_rdData;

  function hit;
    input [7:0] addr;
    input [7:0] target;
    begin
      hit = (addr == target);
    end
  endfunction

  // ==========================================================
  // Input synchronisers
  assign syncIn = {thermistorBelowRef, lightAboveRef, flashTriggerPin};

  lmp_sync #(
    .W(3)
  ) uSync (
    .clk     (clk),
    .reset_n (reset_n),
    .din     (syncIn),
    .dout    (syncOut)
  );

  assign trigPin   = syncOut[0];
  assign lightHigh = syncOut[1];
  assign thermLow  = syncOut[2];

  // ==========================================================
  // Register writes
  // Written values take effect on the cycle after the strobe.
  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      cfgA     <= `LMP_RST_CFG_A;
      cfgB     <= `LMP_RST_CFG_B;
      torchReg <= `LMP_RST_TORCH;
      phRef    <= `LMP_RST_PHREF;
      thermReg <= `LMP_RST_THERM;
    end
    else
    begin
      if (regWr && hit(regAddr, `LMP_ADDR_CFG_A))
        cfgA <= regWrData;
      if (regWr && hit(regAddr, `LMP_ADDR_CFG_B))
        cfgB <= regWrData;
      if (regWr && hit(regAddr, `LMP_ADDR_TORCH))
        torchReg <= regWrData;
      if (regWr && hit(regAddr, `LMP_ADDR_PHREF))
        phRef <= regWrData;
      if (regWr && hit(regAddr, `LMP_ADDR_THERM))
        thermReg <= regWrData;
    end
  end

  // ==========================================================
  // Mode decode
  assign indicatorEn = cfgB[`LMP_B_IND_EN];
  assign flashSelect = cfgB[`LMP_B_FLASH_SEL];
  assign ledAny      = cfgA[`LMP_A_LED1] | cfgA[`LMP_A_LED2];
  // Thermal fault kills the pump and every high-current mode.
  assign pumpReq     = cfgB[`LMP_B_PUMP_EN] & ~thermFault;
  // Light latch blocks the pulse until the next trigger.
  assign flashActive = flashSelect & flashPulseRequest & pumpReq & ~lightLatch;
  // Torch is suspended while the indicator is on and resumes after.
  assign torchActive = ~flashSelect & ledAny & pumpReq & ~indicatorEn;
  // Picture light shares the torch mirror but never joins a flash pulse.
  assign plActive    = torchActive & ~flashActive & ~plExpired;
  assign plTimerRun  = torchActive & ((torchReg > `LMP_TORCH_LIMIT) | cfgA[`LMP_A_PL_FORCE]);

  lmp_timer #(
    .LIMIT(PL_TIMEOUT_CYC)
  ) uTimer (
    .clk     (clk),
    .reset_n (reset_n),
    .run     (plTimerRun),
    .done    (plExpired)
  );

  // ==========================================================
  // Photo-sense latch and thermistor latch
  assign rearm = (trigPin & ~trigPinPrev & cfgB[`LMP_B_EXT_TRIG])
               | (cfgB[`LMP_B_I2C_TRIG] & ~i2cTrigPrev);

  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      lightLatch  <= 1'b0;
      thermFault  <= 1'b0;
      clearSeen   <= 1'b0;
      trigPinPrev <= 1'b0;
      i2cTrigPrev <= 1'b0;
    end
    else
    begin
      trigPinPrev <= trigPin;
      i2cTrigPrev <= cfgB[`LMP_B_I2C_TRIG];
      // Detection during the pulse beats a rearm in the same cycle.
      if (cfgA[`LMP_A_PH_SENSE] && flashActive && lightHigh)
        lightLatch <= 1'b1;
      else if (rearm)
        lightLatch <= 1'b0;
      // The clear acts on the falling edge of the clear bit.
      clearSeen <= thermReg[`LMP_T_CLEAR];
      if (cfgA[`LMP_A_THERM_EN] && thermLow)
        thermFault <= 1'b1;
      else if (clearSeen && !thermReg[`LMP_T_CLEAR])
        thermFault <= 1'b0;
    end
  end

  // ==========================================================
  // Outputs
  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      flashOn               <= 1'b0;
      torchOn               <= 1'b0;
      pictureLightOn        <= 1'b0;
      indicatorFirstOn      <= 1'b0;
      indicatorSecondOn     <= 1'b0;
      gateDriveFirst        <= 1'b0;
      gateDriveSecond       <= 1'b0;
      pumpOn                <= 1'b0;
      sensorBiasOut         <= 1'b0;
      flashTimeoutEnable    <= 1'b0;
      pictureTimeoutExpired <= 1'b0;
      torchCurrentLevel     <= 8'h00;
      photoReference        <= 8'h00;
      thermistorThreshold   <= 7'h00;
      regRdData             <= 8'h00;
    end
    else
    begin
      flashOn          <= flashActive;
      torchOn          <= torchActive;
      pictureLightOn   <= plActive;
      // Indicator current adds to flash current; torch is suspended while the indicator is on.
      indicatorFirstOn <= indicatorEn;
      indicatorSecondOn <= 1'b0;
      // Only a flash pulse drives the gates; a flash outranks the indicator.
      gateDriveFirst   <= flashActive & cfgA[`LMP_A_LED1];
      gateDriveSecond  <= flashActive & cfgA[`LMP_A_LED2];
      pumpOn           <= pumpReq;
      sensorBiasOut    <= pumpReq | cfgA[`LMP_A_PH_BIAS];
      // Indicator and torch never start the flash time-out; a flash keeps it for safety.
      flashTimeoutEnable <= flashActive;
      pictureTimeoutExpired <= plExpired;
      torchCurrentLevel <= torchReg;
      photoReference   <= phRef;
      thermistorThreshold <= thermReg[6:0];
      regRdData        <= next_rdData;
    end
  end

  // ==========================================================
  // Read mux
  // Unmapped addresses read as zero; data appear one cycle after regRd.
  always @*
  begin
    next_rdData = 8'h00;
    if (regRd)
    begin
      case (regAddr)
        `LMP_ADDR_CFG_A:  next_rdData = cfgA;
        `LMP_ADDR_CFG_B:  next_rdData = cfgB;
        `LMP_ADDR_TORCH:  next_rdData = torchReg;
        `LMP_ADDR_PHREF:  next_rdData = phRef;
        `LMP_ADDR_THERM:  next_rdData = thermReg;
        `LMP_ADDR_STATUS: next_rdData = {3'h0, plExpired, thermFault, lightLatch, torchActive, flashActive};
        default:          next_rdData = 8'h00;
      endcase
    end
  end
endmodule
`default_nettype wire

// ===== verif/lmp_ctrl_checker.sv
/* Concurrent checks on the ports of lmp_led_mode_ctrl.
   Assumes one clock and a synchronous active-low reset. */
`timescale 1ns/1ps
`default_nettype none
`include "lmp_defines.vh"
// ==========================================================
// Checker
module lmp_ctrl_checker #(
  parameter [31:0] PL_TIMEOUT_CYC = 32'd50
) (
  input wire logic       clk,
  input wire logic       reset_n,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic       regWr,
  input wire logic       regRd,
  input wire logic [7:0] regRdData,
  input wire logic       flashOn,
  input wire logic       torchOn,
  input wire logic       pictureLightOn,
  input wire logic       indicatorFirstOn,
  input wire logic       indicatorSecondOn,
  input wire logic       gateDriveFirst,
  input wire logic       gateDriveSecond,
  input wire logic       pumpOn,
  input wire logic       sensorBiasOut,
  input wire logic       flashTimeoutEnable,
  input wire logic       pictureTimeoutExpired,
  input wire logic [7:0] torchCurrentLevel
);
  // A few cycles of slack cover the register and timer pipeline.
  logic [31:0] hiCnt;
  always_ff @(posedge clk)
    if (!reset_n || !(torchOn && torchCurrentLevel > `LMP_TORCH_LIMIT))
      hiCnt <= 32'h0;
    else
      hiCnt <= hiCnt + 32'h1;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_ind_second: assert property (indicatorSecondOn == 1'b0)
    else $error("second indicator driven");
  a_gate_zero: assert property (indicatorFirstOn && !flashOn && !$past(flashOn)
    |-> !gateDriveFirst && !gateDriveSecond) else $error("gate driven in indicator");
  a_ind_timeout: assert property (indicatorFirstOn && !flashOn && !$past(flashOn)
    |-> !flashTimeoutEnable) else $error("timeout on in indicator");
  a_torch_timeout: assert property (torchOn && $past(torchOn) |-> !flashTimeoutEnable)
    else $error("timeout on in torch");
  a_flash_plight: assert property (!(flashOn && pictureLightOn))
    else $error("flash with picture light");
  a_bias_follow: assert property ($rose(pumpOn) |-> ##[0:2] sensorBiasOut)
    else $error("bias off with pump");
  a_expiry_stop: assert property (pictureTimeoutExpired [*2] |-> !pictureLightOn)
    else $error("picture light after expiry");
  a_level_timeout: assert property (hiCnt > PL_TIMEOUT_CYC + 32'd6 |-> pictureTimeoutExpired)
    else $error("high level did not time out");
  a_rd_idle: assert property (!regRd |=> regRdData == 8'h00)
    else $error("read data without read");
  a_level_write: assert property (regWr && regAddr == `LMP_ADDR_TORCH
    |-> ##2 torchCurrentLevel == $past(regWrData, 2)) else $error("level not written");
endmodule
bind lmp_led_mode_ctrl lmp_ctrl_checker #(.PL_TIMEOUT_CYC(PL_TIMEOUT_CYC)) i_chk (
  .clk, .reset_n, .regAddr, .regWrData, .regWr, .regRd, .regRdData, .flashOn, .torchOn,
  .pictureLightOn, .indicatorFirstOn, .indicatorSecondOn, .gateDriveFirst, .gateDriveSecond,
  .pumpOn, .sensorBiasOut, .flashTimeoutEnable, .pictureTimeoutExpired, .torchCurrentLevel);
`default_nettype wire

// ===== verif/lmp_mcu_model.sv
/* Host controller model driving the byte register port.
   Assumes the design clock; callers run one access at a time. */
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Host model
module lmp_mcu_model (
  input  wire logic       clk,
  input  wire logic [7:0] regRdData,
  output var  logic [7:0] regAddr,
  output var  logic [7:0] regWrData,
  output var  logic       regWr,
  output var  logic       regRd
);
  initial {regAddr, regWrData, regWr, regRd} = 18'h0;
  // The leading edge wait keeps a strobe from rising in the step that lowered it.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr   <= a;
    regWrData <= d;
    regWr     <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1 d = regRdData;
  endtask
endmodule
`default_nettype wire

// ===== verif/lmp_led_mode_ctrl_tb_top.sv
/* Self-checking bench for lmp_led_mode_ctrl.
   Assumes the checker is bound in and the host model owns the register port. */
`timescale 1ns/1ps
`default_nettype none
`include "lmp_defines.vh"
// ==========================================================
// Bench
module lmp_led_mode_ctrl_tb_top;
  localparam int PL = 50;
  logic       clk = 1'b0, reset_n = 1'b0;
  logic       trigPin = 1'b0, lightHi = 1'b0, coldNtc = 1'b0, flashReq = 1'b0;
  wire  [7:0] addr, wdata, rdata, level, pref;
  wire  [6:0] nthr;
  wire        wr, rd, fOn, tOn, plOn, i1, i2, g1, g2, pump, bias, fto, plExp;
  int         numErrors = 0, nTests = 0, seed = 65816;
  always #10 clk = ~clk;
  lmp_mcu_model i_mcu (.clk, .regRdData(rdata), .regAddr(addr), .regWrData(wdata), .regWr(wr), .regRd(rd));
  lmp_led_mode_ctrl #(.PL_TIMEOUT_CYC(PL)) i_dut (.clk, .reset_n, .regAddr(addr), .regWrData(wdata),
    .regWr(wr), .regRd(rd), .regRdData(rdata), .flashTriggerPin(trigPin), .lightAboveRef(lightHi),
    .thermistorBelowRef(coldNtc), .flashPulseRequest(flashReq), .flashOn(fOn), .torchOn(tOn),
    .pictureLightOn(plOn), .indicatorFirstOn(i1), .indicatorSecondOn(i2), .gateDriveFirst(g1),
    .gateDriveSecond(g2), .pumpOn(pump), .sensorBiasOut(bias), .flashTimeoutEnable(fto),
    .pictureTimeoutExpired(plExp), .torchCurrentLevel(level), .photoReference(pref),
    .thermistorThreshold(nthr));
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    nTests++;
    if (s !== e)
    begin
      numErrors++;
      $display("MISMATCH %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d errors %0d", nTests, numErrors);
    if (numErrors == 0 && nTests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic w(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic st(input int b, input logic e);
    logic [7:0] d;
    i_mcu.rd(`LMP_ADDR_STATUS, d);
    chk("status", {7'h0, d[b]}, {7'h0, e});
  endtask
  task automatic cl;
    i_mcu.wr(`LMP_ADDR_THERM, 8'h80);
    i_mcu.wr(`LMP_ADDR_THERM, 8'h00);
    w(3);
  endtask
  // The run needs under a thousand cycles; the limit leaves wide margin.
  initial
  begin
    repeat (5000) @(posedge clk);
    numErrors++;
    finish_test;
  end
  initial
  begin
    logic [7:0] d;
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    w(1);
    chk("level", level, `LMP_RST_TORCH);
    repeat (4)
    begin
      d = 8'($random(seed));
      i_mcu.wr(`LMP_ADDR_TORCH, d);
      w(1);
      chk("level", level, d);
    end
    i_mcu.rd(8'h33, d);
    chk("unmapped", d, 8'h00);
    i_mcu.wr(`LMP_ADDR_PHREF, 8'h40);
    i_mcu.wr(`LMP_ADDR_CFG_A, 8'h03);
    i_mcu.wr(`LMP_ADDR_TORCH, 8'h3F);
    i_mcu.wr(8'h0F, 8'h00);
    i_mcu.wr(`LMP_ADDR_CFG_B, 8'h46);
    w(3);
    chk("torch", tOn, 1);
    chk("fto", fto, 0);
    chk("bias", bias, 1);
    chk("pref", pref, 8'h40);
    w(PL + 10);
    chk("plExp", plExp, 0);
    i_mcu.wr(`LMP_ADDR_TORCH, 8'h40);
    w(PL + 10);
    chk("plExp", plExp, 1);
    chk("plOn", plOn, 0);
    st(4, 1);
    i_mcu.wr(`LMP_ADDR_TORCH, 8'h10);
    i_mcu.wr(`LMP_ADDR_CFG_A, 8'h43);
    w(PL + 10);
    chk("plExp", plExp, 1);
    i_mcu.wr(`LMP_ADDR_CFG_A, 8'h03);
    w(3);
    chk("plOn", plOn, 1);
    i_mcu.wr(`LMP_ADDR_CFG_B, 8'hC6);
    w(3);
    chk("ind1", i1, 1);
    chk("ind2", i2, 0);
    chk("torch", tOn, 0);
    chk("gates", {g1, g2}, 0);
    i_mcu.wr(`LMP_ADDR_CFG_B, 8'h46);
    w(3);
    chk("torch", tOn, 1);
    i_mcu.wr(`LMP_ADDR_THERM, 8'h25);
    i_mcu.wr(`LMP_ADDR_CFG_A, 8'h0B);
    coldNtc <= 1'b1;
    w(6);
    chk("nthr", {1'b0, nthr}, 8'h25);
    chk("pump", pump, 0);
    chk("torch", tOn, 0);
    cl;
    st(3, 1);
    coldNtc <= 1'b0;
    w(6);
    chk("torch", tOn, 0);
    cl;
    st(3, 0);
    chk("torch", tOn, 1);
    i_mcu.wr(`LMP_ADDR_CFG_A, 8'h23);
    i_mcu.wr(`LMP_ADDR_CFG_B, 8'h2E);
    flashReq <= 1'b1;
    w(3);
    chk("flash", fOn, 1);
    lightHi <= 1'b1;
    w(5);
    chk("flash", fOn, 0);
    lightHi <= 1'b0;
    w(5);
    chk("flash", fOn, 0);
    st(2, 1);
    trigPin <= 1'b1;
    w(5);
    chk("flash", fOn, 1);
    chk("plOn", plOn, 0);
    chk("fto", fto, 1);
    i_mcu.wr(`LMP_ADDR_CFG_B, 8'hAE);
    w(3);
    chk("ind1", i1, 1);
    chk("flash", fOn, 1);
    chk("gates", {g1, g2}, 8'h03);
    lightHi <= 1'b1;
    w(5);
    chk("flash", fOn, 0);
    lightHi <= 1'b0;
    w(3);
    i_mcu.wr(`LMP_ADDR_CFG_B, 8'hBE);
    w(3);
    chk("flash", fOn, 1);
    flashReq <= 1'b0;
    i_mcu.wr(`LMP_ADDR_CFG_B, 8'h00);
    i_mcu.wr(`LMP_ADDR_CFG_A, 8'h10);
    w(3);
    chk("bias", bias, 1);
    i_mcu.wr(`LMP_ADDR_CFG_A, 8'h00);
    w(3);
    chk("bias", bias, 0);
    i_mcu.wr(`LMP_ADDR_CFG_A, 8'h08);
    coldNtc <= 1'b1;
    w(6);
    st(3, 1);
    reset_n <= 1'b0;
    w(2);
    coldNtc <= 1'b0;
    reset_n <= 1'b1;
    w(3);
    chk("level", level, `LMP_RST_TORCH);
    st(3, 0);
    finish_test;
  end
endmodule
`default_nettype wire
